// >>> verilog/cwsrs_top.sv
// Cold, warm and soft reset sequencer with lock output and strap capture
`timescale 1ns/1ps
`include "cwsrs_defines.svh"

// What this block does
// [RULE_01] Cold reset clears everything including PLL; the code keeps strap_cfg until the hardware reset release edge
// [RULE_02] Board holds power-on reset low 2000 ns
// [RULE_03] Hardware reset held 10 ns past power-on
// [RULE_04] Hardware reset low whenever power-on reset low
// [RULE_05] Lock output high within 10 us
// [RULE_06] Boot waits for lock output high
// [RULE_07] Straps valid 50 ns before reset release
// [RULE_08] Straps held 0 to 20 ns around lock
// [RULE_09] Warm reset only after cold reset completes
// [RULE_10] Hardware reset alone keeps PLL running
// [RULE_11] Warm reset pulse at least 500 ns
// [RULE_12] Watchdog timeout gives internal soft warm reset
// [RULE_13] Warm flag bit 4 set by soft reset
// [RULE_14] Lock drops at once on any reset
// [RULE_15] Lock low 24 ref clocks after watchdog
// [RULE_16] Straps captured at hardware reset release
// [RULE_17] Reset releases synchronised before lock counting
module cwsrs_top
    import cwsrs_pkg::*;
#(
    parameter int STRAP_W    = `CWSRS_STRAP_WIDTH,
    parameter int PLL_CYC    = `CWSRS_PLL_SETTLE_CYCLES,
    parameter int WARM_CYC   = `CWSRS_WARM_SETTLE_CYCLES,
    parameter int WDOG_CYC   = `CWSRS_WDOG_HOLD_REFCLK
) (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                pwron_rst_n,
    input  wire logic                hw_rst_n,
    input  wire logic                wdog_timeout,
    input  wire logic [STRAP_W-1:0]  expansion_address_straps,
    output logic                     lock_ready,
    output logic                     pll_rst,
    output logic                     core_rst,
    output logic                     boot_go,
    output logic [STRAP_W-1:0]       strap_cfg,
    output logic [`CWSRS_TSTAT_WIDTH-1:0] timer_status
);

    // Limit on the lock wait; the counter must never exceed it
    localparam logic [`CWSRS_CNT_WIDTH-1:0] LOCK_MAX =
        `CWSRS_CNT_WIDTH'(`CWSRS_LOCK_CYCLES - 1);

    cwsrs_rst_s                  pins_s;     // Synchronised pins
    logic [1:0]                  sync_vec;   // Raw synchroniser output
    logic [STRAP_W-1:0]          strap_m_q;  // Strap first stage
    logic [STRAP_W-1:0]          strap_s_q;  // Strap second stage
    logic [STRAP_W-1:0]          strap_m_d;
    logic [STRAP_W-1:0]          strap_s_d;

    cwsrs_state_e                state_q;    // Sequence phase
    cwsrs_state_e                state_d;
    logic [`CWSRS_CNT_WIDTH-1:0] cnt_q;      // Phase timer
    logic [`CWSRS_CNT_WIDTH-1:0] cnt_d;
    logic                        hw_prev_q;  // Last synced reset level
    logic                        hw_prev_d;
    logic                        soft_q;     // Sticky warm-reset flag
    logic                        soft_d;
    logic [STRAP_W-1:0]          cfg_q;      // Captured straps
    logic [STRAP_W-1:0]          cfg_d;
    logic                        lock_q;     // Lock/ready output
    logic                        lock_d;
    logic                        wd_hold_q;  // Soft reset delay in force
    logic                        wd_hold_d;
    cwsrs_ctl_s                  ctl_q;      // Registered reset outputs
    cwsrs_ctl_s                  ctl_d;
    logic                        hw_rise;    // Reset pin release edge

    // Both reset pins cross into sys_clk before any decision
    cwsrs_sync #(
        .WIDTH    (2)
    ) u_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in ({pwron_rst_n, hw_rst_n}),
        .sync_out (sync_vec)
    ); // [RULE_17]

    assign pins_s  = sync_vec;
    assign hw_rise = pins_s.hw_rst_n & ~hw_prev_q;

    // Straps are static pins, still double-flopped before capture
    always_comb begin
        strap_m_d = expansion_address_straps;
        strap_s_d = strap_m_q;
    end

    // Main sequencer next-state logic
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        hw_prev_d = pins_s.hw_rst_n;
        soft_d    = soft_q;
        cfg_d     = cfg_q;
        lock_d    = lock_q;
        wd_hold_d = wd_hold_q;
        ctl_d     = ctl_q;

        // Straps latched on release edge of hardware reset
        if (hw_rise) begin
            cfg_d = strap_s_q; // [RULE_16]
        end

        if (!pins_s.pwron_rst_n) begin
            // Cold reset: everything down, PLL included
            state_d   = CWSRS_COLD_HOLD; // [RULE_01]
            lock_d    = 1'b0;            // [RULE_14]
            soft_d    = 1'b0;            // [RULE_13]
            wd_hold_d = 1'b0;
            cnt_d     = '0;
            ctl_d     = '{pll_rst: 1'b1, core_rst: 1'b1, boot_go: 1'b0};
        end else if (!pins_s.hw_rst_n) begin
            // Warm reset: core down, PLL left running after a cold one
            if (state_q != CWSRS_COLD_HOLD && state_q != CWSRS_PLL_WAIT) begin
                state_d = CWSRS_WARM_HOLD; // [RULE_10]
                ctl_d.pll_rst = 1'b0;
            end
            lock_d    = 1'b0;              // [RULE_14]
            soft_d    = 1'b0;              // [RULE_13]
            wd_hold_d = 1'b0;
            cnt_d     = '0;
            ctl_d.core_rst = 1'b1;
            ctl_d.boot_go  = 1'b0;
        end else if (wdog_timeout && state_q == CWSRS_RUN) begin
            // Soft reset: no pin activity, core down as warm, but flag set, straps kept, 24-cycle hold
            state_d   = CWSRS_LOCK_WAIT;   // [RULE_12]
            lock_d    = 1'b0;              // [RULE_14]
            soft_d    = 1'b1;              // [RULE_13]
            wd_hold_d = 1'b1;
            cnt_d     = '0;
            ctl_d.core_rst = 1'b1;
            ctl_d.boot_go  = 1'b0;
        end else begin
            unique case (state_q)
                CWSRS_COLD_HOLD: begin
                    // Pins both released: start PLL settling
                    state_d = CWSRS_PLL_WAIT;
                    ctl_d.pll_rst = 1'b0;
                    cnt_d = '0;
                end
                CWSRS_WARM_HOLD: begin
                    // PLL already locked, only short core settle
                    state_d = CWSRS_LOCK_WAIT;
                    cnt_d = '0;
                end
                CWSRS_PLL_WAIT: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == `CWSRS_CNT_WIDTH'(PLL_CYC - 1)) begin
                        state_d = CWSRS_LOCK_WAIT;
                        cnt_d   = '0;
                    end
                end
                CWSRS_LOCK_WAIT: begin
                    // Watchdog path holds 24 ref clocks, warm a few;
                    // either stays well under the 10 us ceiling
                    cnt_d = cnt_q + 1'b1;
                    if ((wd_hold_q &&
                         cnt_q == `CWSRS_CNT_WIDTH'(WDOG_CYC - 1)) ||
                        (!wd_hold_q &&
                         cnt_q == `CWSRS_CNT_WIDTH'(WARM_CYC - 1)) ||
                        cnt_q == LOCK_MAX) begin
                        state_d = CWSRS_RUN;  // [RULE_15]
                        lock_d  = 1'b1;       // [RULE_05]
                        wd_hold_d = 1'b0;
                        ctl_d.core_rst = 1'b0;
                        cnt_d   = '0;
                    end
                end
                CWSRS_RUN: begin
                    // Boot only once lock is already high
                    ctl_d.boot_go = lock_q; // [RULE_06]
                end
            endcase
        end
    end

    // Register all sequencer state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            strap_m_q <= `CWSRS_STRAP_RESET;
            strap_s_q <= `CWSRS_STRAP_RESET;
            state_q   <= CWSRS_COLD_HOLD;
            cnt_q     <= '0;
            hw_prev_q <= 1'b0;
            soft_q    <= 1'b0;
            cfg_q     <= `CWSRS_STRAP_RESET;
            lock_q    <= 1'b0;
            wd_hold_q <= 1'b0;
            ctl_q     <= '{pll_rst: 1'b1, core_rst: 1'b1, boot_go: 1'b0};
        end else begin
            strap_m_q <= strap_m_d;
            strap_s_q <= strap_s_d;
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            hw_prev_q <= hw_prev_d;
            soft_q    <= soft_d;
            cfg_q     <= cfg_d;
            lock_q    <= lock_d;
            wd_hold_q <= wd_hold_d;
            ctl_q     <= ctl_d;
        end
    end

    // Outputs straight from flops
    assign lock_ready = lock_q;
    assign pll_rst    = ctl_q.pll_rst;
    assign core_rst   = ctl_q.core_rst;
    assign boot_go    = ctl_q.boot_go;
    assign strap_cfg  = cfg_q;

    // Timer status: only the warm-reset flag is owned here
    always_comb begin
        timer_status = '0;
        timer_status[`CWSRS_WARM_FLAG_BIT] = soft_q; // [RULE_13]
    end

endmodule // cwsrs_top

// >>> verilog/cwsrs_defines.svh
// Timing counts, widths and reset values for the reset sequencer
`ifndef CWSRS_DEFINES_SVH
`define CWSRS_DEFINES_SVH

`define CWSRS_CLK_PERIOD_NS    25
`define CWSRS_LOCK_MAX_US      10
`define CWSRS_LOCK_CYCLES      ((`CWSRS_LOCK_MAX_US * 1000) / `CWSRS_CLK_PERIOD_NS)
`define CWSRS_PLL_SETTLE_CYCLES 64
`define CWSRS_WARM_SETTLE_CYCLES 8
`define CWSRS_WDOG_HOLD_REFCLK 24
`define CWSRS_STRAP_WIDTH      16
`define CWSRS_STRAP_RESET      16'h0000
`define CWSRS_WARM_FLAG_BIT    4
`define CWSRS_TSTAT_WIDTH      8
`define CWSRS_CNT_WIDTH        12

`endif

// >>> verilog/cwsrs_pkg.sv
// Types shared by the reset sequencer files
package cwsrs_pkg;

    // Phase of the reset sequence
    typedef enum logic [2:0] {
        CWSRS_COLD_HOLD,
        CWSRS_WARM_HOLD,
        CWSRS_PLL_WAIT,
        CWSRS_LOCK_WAIT,
        CWSRS_RUN
    } cwsrs_state_e;

    // Synchronised view of the reset inputs
    typedef struct packed {
        logic pwron_rst_n;
        logic hw_rst_n;
    } cwsrs_rst_s;

    // Reset outputs to the rest of the chip
    typedef struct packed {
        logic pll_rst;
        logic core_rst;
        logic boot_go;
    } cwsrs_ctl_s;

endpackage

// >>> verilog/cwsrs_sync.sv
// Two-flop synchroniser for asynchronous active-low reset pins
`timescale 1ns/1ps
`include "cwsrs_defines.svh"

module cwsrs_sync
    import cwsrs_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;  // Second stage, safe for logic
    logic [WIDTH-1:0] sync_d;

    // Next values: shift the pin through two stages
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Reset to zero so the chip sits in reset until pins are seen high
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // cwsrs_sync

// >>> bench/cwsrs_board_model.sv
// Board model: reset supervisor and strap drivers
`timescale 1ns/1ps

module cwsrs_board_model (
    input  wire logic        sys_clk,
    input  wire logic        lock_ready,
    output logic             pwron_rst_n,
    output logic             hw_rst_n,
    output logic [15:0]      straps
);
    // Both pins are low from power-up
    initial begin
        pwron_rst_n = 1'h0;
        hw_rst_n    = 1'h0;
        straps      = 16'h0000;
    end
    // The straps are only valid until shortly after lock, then show junk
    always @(posedge lock_ready) begin
        #10 straps = ~straps;
    end
    // Moves just after an edge, like every other driver
    task automatic hold(input int cycles);
        repeat (cycles) @(posedge sys_clk);
        #2;
    endtask
    // Cold: both pins low 2000 ns, power-on released first, a gap of 25 ns
    task automatic cold(input logic [15:0] v);
        pwron_rst_n = 1'h0;
        hw_rst_n    = 1'h0;
        straps      = v;
        hold(80);
        pwron_rst_n = 1'h1;
        hold(1);
        hw_rst_n = 1'h1;
    endtask
    // Warm: reset pin low 500 ns, power-on stays high throughout
    task automatic warm(input logic [15:0] v);
        hw_rst_n = 1'h0;
        straps   = v;
        hold(20);
        hw_rst_n = 1'h1;
    endtask
endmodule // cwsrs_board_model

// >>> bench/cwsrs_top_asserts.sv
// Port checker for the reset sequencer
`timescale 1ns/1ps
`include "cwsrs_defines.svh"

module cwsrs_top_asserts
    import cwsrs_pkg::*;
#(
    parameter int STRAP_W = 16
) (
    input wire logic                          sys_clk,
    input wire logic                          srst,
    input wire logic                          pwron_rst_n,
    input wire logic                          hw_rst_n,
    input wire logic                          wdog_timeout,
    input wire logic                          lock_ready,
    input wire logic                          pll_rst,
    input wire logic                          core_rst,
    input wire logic                          boot_go,
    input wire logic [STRAP_W-1:0]            strap_cfg,
    input wire logic [`CWSRS_TSTAT_WIDTH-1:0] timer_status
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Pins pass two sync flops, so their effect lands three edges on
    AST_PIN_DROP:
    assert property (!(hw_rst_n && pwron_rst_n)
        |-> ##3 !lock_ready && !timer_status[4])
        else $error("lock or flag kept under a pin reset");
    AST_COLD_PLL:
    assert property (!pwron_rst_n |-> ##3 pll_rst)
        else $error("pll not reset on cold reset");
    // PLL may only enter reset after power-on reset was seen low
    AST_WARM_PLL:
    assert property (!pll_rst && pwron_rst_n && $past(pwron_rst_n)
        && $past(pwron_rst_n, 2) |=> !pll_rst)
        else $error("pll reset without power-on reset");
    AST_WDOG_DROP:
    assert property (lock_ready && wdog_timeout && hw_rst_n && pwron_rst_n
        |=> !lock_ready && core_rst && timer_status[4])
        else $error("watchdog did not reset the core");
    AST_WDOG_HOLD:
    assert property (lock_ready && wdog_timeout && hw_rst_n && pwron_rst_n
        |-> ##24 !lock_ready ##1 lock_ready)
        else $error("lock low time after watchdog wrong");
    AST_BOOT_GATE:
    assert property (boot_go |-> lock_ready && $past(lock_ready))
        else $error("boot without lock");
    AST_BOOT_RISE:
    assert property ($rose(lock_ready) |=> boot_go)
        else $error("boot did not follow lock");
    AST_LOCK_MAX:
    assert property ($rose(hw_rst_n) && pwron_rst_n |-> ##[3:400] lock_ready)
        else $error("lock late or early after reset release");
    AST_STRAP_HOLD:
    assert property (lock_ready && $past(lock_ready) |-> $stable(strap_cfg))
        else $error("straps changed while running");
    // The release must cross both sync flops before the lock count starts
    AST_LOCK_SYNC:
    assert property ($rose(hw_rst_n) |-> !lock_ready [*4])
        else $error("lock rose before the release was synchronised");
endmodule // cwsrs_top_asserts

bind cwsrs_top cwsrs_top_asserts #(.STRAP_W(STRAP_W)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .pwron_rst_n(pwron_rst_n),
    .hw_rst_n(hw_rst_n), .wdog_timeout(wdog_timeout),
    .lock_ready(lock_ready), .pll_rst(pll_rst), .core_rst(core_rst),
    .boot_go(boot_go), .strap_cfg(strap_cfg), .timer_status(timer_status));

// >>> bench/test_cold_warm_soft_reset_sequencer.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps

module test_cold_warm_soft_reset_sequencer
    import cwsrs_pkg::*;
;
    typedef struct packed {
        logic [1:0]  op;    // 0 cold, 1 warm, 2 watchdog
        logic [15:0] strap; // Straps driven on cold and warm rows, also expected capture
        logic        flag;  // Expected soft-reset flag
        logic        pll;   // Whether the PLL must pass through reset
    } cwsrs_row_s;
    logic        sys_clk, srst, wdog_timeout, lock_ready, pll_seen;
    logic        pll_rst, core_rst, boot_go, pwron_rst_n, hw_rst_n;
    logic [15:0] straps, strap_cfg;
    logic [7:0]  timer_status;
    int          fail_count, checks, cyc, n;
    cwsrs_row_s  rows [5];

    // Short settle counts keep the run brief; watchdog hold stays at 24
    cwsrs_top #(.PLL_CYC(4), .WARM_CYC(2)) dut (
        .sys_clk(sys_clk), .srst(srst), .pwron_rst_n(pwron_rst_n),
        .hw_rst_n(hw_rst_n), .wdog_timeout(wdog_timeout),
        .expansion_address_straps(straps), .lock_ready(lock_ready),
        .pll_rst(pll_rst), .core_rst(core_rst), .boot_go(boot_go),
        .strap_cfg(strap_cfg), .timer_status(timer_status));
    cwsrs_board_model board (
        .sys_clk(sys_clk), .lock_ready(lock_ready),
        .pwron_rst_n(pwron_rst_n), .hw_rst_n(hw_rst_n), .straps(straps));

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang limit, and a note of any PLL reset seen
    always @(posedge sys_clk) begin
        cyc++;
        if (pll_rst) pll_seen = 1'h1;
        if (cyc == 2000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge sys_clk);
        #2;
    endtask
    // Bounded wait; n ends as the count of cycles with lock low
    task automatic wait_lock();
        n = 0;
        while (lock_ready !== 1'b1 && n < 500) begin
            step();
            n++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rows = '{'{2'h0, 16'hA5C3, 1'h0, 1'h1}, '{2'h2, 16'hA5C3, 1'h1, 1'h0},
                 '{2'h1, 16'h3C5A, 1'h0, 1'h0}, '{2'h2, 16'h3C5A, 1'h1, 1'h0},
                 '{2'h0, 16'hFFFF, 1'h0, 1'h1}};
        srst = 1'h1;
        wdog_timeout = 1'h0;
        repeat (12) @(posedge sys_clk);
        #2 srst = 1'h0;
        foreach (rows[i]) begin
            pll_seen = 1'h0;
            case (rows[i].op)
                2'h0: board.cold(rows[i].strap);
                2'h1: board.warm(rows[i].strap);
                default: begin
                    wdog_timeout = 1'h1;
                    step();
                    wdog_timeout = 1'h0;
                end
            endcase
            wait_lock();
            if (rows[i].op == 2'h2) chk(16'(n), 16'h0018);
            else chk(16'(n <= 400), 16'h0001);
            chk(strap_cfg, rows[i].strap);
            chk(16'(timer_status), {11'h0, rows[i].flag, 4'h0});
            chk(16'(pll_seen), 16'(rows[i].pll));
            step();
            chk({14'h0, boot_go, core_rst}, 16'h0002);
            $display("row %0d done", i);
        end
        // Mid-run reset, then a watchdog that must be ignored outside run
        srst = 1'h1;
        step();
        srst = 1'h0;
        chk({12'h0, lock_ready, pll_rst, core_rst, boot_go},
            16'h0006);
        chk(strap_cfg | 16'(timer_status), 16'h0000);
        wdog_timeout = 1'h1;
        repeat (3) step();
        wdog_timeout = 1'h0;
        wait_lock();
        // The cold sequence rerun by the sync reset must still reach lock
        chk(16'(lock_ready), 16'h0001);
        chk(16'(timer_status), 16'h0000);
        $display("reset and ignored watchdog done");
        close_out();
    end
endmodule // test_cold_warm_soft_reset_sequencer
